//--- shared/dcl_defines.svh
// constants of the default configuration loader
// assumes inclusion by bare name from rtl and bench
`ifndef DCL_DEFINES_SVH
`define DCL_DEFINES_SVH
`define DCL_ADDR_BUS_SETTINGS 8'hA0
`define DCL_ADDR_CONTROL_FIRST 8'hA1
`define DCL_ADDR_CONTROL_SECOND 8'hA2
`define DCL_ADDR_FLAGS 8'h90
`define DCL_ADDR_PAGE 8'h91
`define DCL_IMG_BUS_SETTINGS 8'h00
`define DCL_IMG_CONTROL_FIRST 8'h02
`define DCL_IMG_CONTROL_SECOND 8'h05
`define DCL_TRIAL_I2C_ADDR 7'h08
`define DCL_MIRROR_PAGE 3'h1
`define DCL_BIT_TRIM 0
`define DCL_BIT_FUSE 1
`define DCL_BIT_STEST 2
`define DCL_NUM_BYTES 3
`endif

//--- shared/dcl_pkg.sv
// types of the default configuration loader
// assumes no other package
package dcl_pkg;
  typedef enum {
    DCL_IDLE, DCL_FUSE_LOAD, DCL_COPY, DCL_QOFF, DCL_ON
  } dcl_state_t;
  typedef struct packed {
    logic [7:0] bus_settings;
    logic [7:0] control_first;
    logic [7:0] control_second;
  } dcl_cfg_t;
  typedef struct packed {
    logic stest;
    logic fuse;
    logic trim;
  } dcl_flags_t;
endpackage

//--- rtl/dcl_loader.sv
// default configuration loader: fuse mirror or built-in image into functional registers
// assumes fuse, trim and self-test engines answer with one-cycle done pulses
// Contract
// - source pin low loads from mirror
// - source pin high loads built-in image
// - supply rise copies fuses into mirror when source pin low
// - after fuse load copy mirror to functional
// - mirror writable in trial mode
// - built-in image forbids trial mode
// - fuse mode faults block power-up, clear by 1
// - image mode faults block power-up, clear by 0
// - flags writable only with trial pin high
// - trial pin forces quiescent off state; code still powers up on request when no flag is set
// - self-test flag shows real outcome
// - trial mode disables CRC and secure write
// - trial mode answers at address 0x08
// - trial mode disables all watchdog supervision
// - page select, mirror on page 1 only
// - mirror preloaded from fuses first
// - supply loss resets mirror
// - fuse burn only trial and quiescent off
// - image mode loads trim, fuse flag zero
// - image follows fuse layout, first byte zero
`timescale 1ns/1ps
`include "dcl_defines.svh"
module dcl_loader (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic config_source_pin,
  input wire logic trial_enable_pin,
  input wire logic supply_ok,
  input wire logic [23:0] fuse_data,
  input wire logic fuse_done,
  input wire logic fuse_fail,
  input wire logic trim_done,
  input wire logic trim_fail,
  input wire logic stest_done,
  input wire logic stest_fail,
  input wire logic power_up_request,
  input wire logic low_power_off_select,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  output logic reg_refused,
  output dcl_pkg::dcl_cfg_t functional,
  output logic [6:0] i2c_addr,
  output logic crc_enable,
  output logic secure_write_enable,
  output logic watchdog_enable,
  output logic burn_allowed,
  output logic quiescent_off_state,
  output logic powered_on,
  output logic fuse_load_start
);
  logic rst_s1, rst_s2;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  logic [2:0] sync1, sync2;
  always_ff @(posedge clock or negedge rst_s2) begin
    if (!rst_s2) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else if (clk_en) begin
      sync1 <= {config_source_pin, trial_enable_pin, supply_ok};
      sync2 <= sync1;
    end
  end
  logic src_image, trial_pin, vin_ok;
  assign src_image = sync2[2];
  assign trial_pin = sync2[1];
  assign vin_ok = sync2[0];

  function automatic logic is_mirror_addr(input logic [7:0] a);
    is_mirror_addr = (a == `DCL_ADDR_BUS_SETTINGS) || (a == `DCL_ADDR_CONTROL_FIRST) ||
                     (a == `DCL_ADDR_CONTROL_SECOND);
  endfunction

  dcl_pkg::dcl_state_t state, next_state;
  dcl_pkg::dcl_cfg_t mirror, next_mirror, next_functional;
  dcl_pkg::dcl_flags_t flags, next_flags;
  logic [2:0] page, next_page;
  logic vin_prev, next_vin_prev;
  logic trim_seen, next_trim_seen, stest_seen, next_stest_seen;
  logic fuse_seen, next_fuse_seen;
  logic [7:0] next_rdata;
  logic next_ack, next_refused, next_start;
  logic [6:0] next_i2c_addr;
  logic next_crc, next_secure, next_wdog, next_burn, next_qoff, next_on;
  logic trial_mode;
  dcl_pkg::dcl_cfg_t image;

  // trial mode exists only on the fuse source
  assign trial_mode = trial_pin && !src_image;
  // built-in image laid out as the fuse map
  assign image = '{bus_settings: `DCL_IMG_BUS_SETTINGS,
                   control_first: `DCL_IMG_CONTROL_FIRST,
                   control_second: `DCL_IMG_CONTROL_SECOND};

  always_comb begin
    logic any_flag, mirror_access, flag_wr;
    any_flag = |flags;
    flag_wr = reg_wr && reg_addr == `DCL_ADDR_FLAGS;
    mirror_access = is_mirror_addr(reg_addr) && page == `DCL_MIRROR_PAGE;
    next_state = state;
    next_mirror = mirror;
    next_functional = functional;
    next_flags = flags;
    next_page = page;
    next_vin_prev = vin_ok;
    next_trim_seen = trim_seen;
    next_stest_seen = stest_seen;
    next_fuse_seen = fuse_seen;
    next_rdata = 8'h00;
    next_ack = 1'b0;
    next_refused = 1'b0;
    next_start = 1'b0;

    // flag clearing, writable only with trial pin high
    if (flag_wr && trial_pin && state == dcl_pkg::DCL_QOFF) begin
      for (int i = 0; i < 3; i++) begin
        if (src_image ? !reg_wdata[i] : reg_wdata[i]) begin
          next_flags[i] = 1'b0;
        end
      end
    end
    // events set flags; a set wins over the clear above
    if (trim_done && trim_fail) begin
      next_flags.trim = 1'b1;
    end
    if (fuse_done && fuse_fail && !src_image) begin
      next_flags.fuse = 1'b1;
    end
    if (stest_done) begin
      next_flags.stest = stest_fail;
    end
    if (src_image) begin
      next_flags.fuse = 1'b0;
    end
    if (trim_done) begin
      next_trim_seen = 1'b1;
    end
    if (stest_done) begin
      next_stest_seen = 1'b1;
    end
    if (fuse_done) begin
      next_fuse_seen = 1'b1;
    end

    // register port
    if (reg_wr || reg_rd) begin
      next_ack = 1'b1;
      if (reg_addr == `DCL_ADDR_PAGE) begin
        if (reg_wr) begin
          // extended pages refused outside trial mode
          if (reg_wdata[2:0] != 3'h0 && !trial_mode) begin
            next_refused = 1'b1;
          end else begin
            next_page = reg_wdata[2:0];
          end
        end
        next_rdata = {5'h00, page};
      end else if (reg_addr == `DCL_ADDR_FLAGS) begin
        next_rdata = {5'h00, flags};
      end else if (mirror_access && trial_mode) begin
        if (reg_wr) begin
          case (reg_addr)
            `DCL_ADDR_BUS_SETTINGS: next_mirror.bus_settings = reg_wdata;
            `DCL_ADDR_CONTROL_FIRST: next_mirror.control_first = reg_wdata;
            default: next_mirror.control_second = reg_wdata;
          endcase
        end
        case (reg_addr)
          `DCL_ADDR_BUS_SETTINGS: next_rdata = mirror.bus_settings;
          `DCL_ADDR_CONTROL_FIRST: next_rdata = mirror.control_first;
          default: next_rdata = mirror.control_second;
        endcase
      end else begin
        next_refused = 1'b1;
      end
    end
    if (!trial_mode) begin
      next_page = 3'h0;
    end

    case (state)
      dcl_pkg::DCL_IDLE: begin
        if (vin_ok && !vin_prev) begin
          next_trim_seen = 1'b0;
          next_stest_seen = 1'b0;
          next_fuse_seen = 1'b0;
          next_start = 1'b1; // trim always comes from fuses
          next_state = dcl_pkg::DCL_FUSE_LOAD;
        end
      end
      dcl_pkg::DCL_FUSE_LOAD: begin
        if (fuse_done && !src_image) begin
          next_mirror = fuse_data;
        end
        if ((fuse_seen || fuse_done) && (trim_seen || trim_done) &&
            (stest_seen || stest_done)) begin
          next_state = dcl_pkg::DCL_COPY;
        end
      end
      dcl_pkg::DCL_COPY: begin
        // source choice
        next_functional = src_image ? image : mirror;
        next_state = dcl_pkg::DCL_QOFF;
      end
      dcl_pkg::DCL_QOFF: begin
        // faults block power-up; without the trial pin low-power-off select holds here
        // with the trial pin high the low-power-off choice is ignored
        if (power_up_request && !any_flag && !trial_pin && !low_power_off_select) begin
          next_state = dcl_pkg::DCL_ON;
        end else if (power_up_request && !any_flag && trial_pin) begin
          next_state = dcl_pkg::DCL_ON; // limited functionality run
        end
      end
      dcl_pkg::DCL_ON: begin
        if (!power_up_request) begin
          next_functional = src_image ? image : mirror; // reload on return
          next_state = dcl_pkg::DCL_QOFF;
        end
      end
      default: next_state = dcl_pkg::DCL_IDLE;
    endcase
    if (!vin_ok) begin
      next_state = dcl_pkg::DCL_IDLE;
      next_mirror = '0;
    end

    // outputs follow the next state so each lines up with the state it reports
    // trial pin overrides bus settings; bits 6:0 are ORed into the address, bit 7 crc
    next_i2c_addr = trial_pin ? `DCL_TRIAL_I2C_ADDR :
                    (`DCL_TRIAL_I2C_ADDR | next_functional.bus_settings[6:0]);
    next_crc = !trial_pin && next_functional.bus_settings[7];
    next_secure = !trial_pin && next_functional.control_first[7];
    next_wdog = !trial_pin;
    next_burn = trial_mode && next_state == dcl_pkg::DCL_QOFF;
    next_qoff = next_state == dcl_pkg::DCL_QOFF;
    next_on = next_state == dcl_pkg::DCL_ON;
  end

  always_ff @(posedge clock or negedge rst_s2) begin
    if (!rst_s2) begin
      state <= dcl_pkg::DCL_IDLE;
      mirror <= '0;
      functional <= '0;
      flags <= '0;
      page <= 3'h0;
      vin_prev <= 1'b0;
      trim_seen <= 1'b0;
      stest_seen <= 1'b0;
      fuse_seen <= 1'b0;
      reg_rdata <= 8'h00;
      reg_ack <= 1'b0;
      reg_refused <= 1'b0;
      fuse_load_start <= 1'b0;
      i2c_addr <= `DCL_TRIAL_I2C_ADDR;
      crc_enable <= 1'b0;
      secure_write_enable <= 1'b0;
      watchdog_enable <= 1'b0;
      burn_allowed <= 1'b0;
      quiescent_off_state <= 1'b0;
      powered_on <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      mirror <= next_mirror;
      functional <= next_functional;
      flags <= next_flags;
      page <= next_page;
      vin_prev <= next_vin_prev;
      trim_seen <= next_trim_seen;
      stest_seen <= next_stest_seen;
      fuse_seen <= next_fuse_seen;
      reg_rdata <= next_rdata;
      reg_ack <= next_ack;
      reg_refused <= next_refused;
      fuse_load_start <= next_start;
      i2c_addr <= next_i2c_addr;
      crc_enable <= next_crc;
      secure_write_enable <= next_secure;
      watchdog_enable <= next_wdog;
      burn_allowed <= next_burn;
      quiescent_off_state <= next_qoff;
      powered_on <= next_on;
    end
  end
endmodule

//--- bench/dcl_engine_model.sv
// engine model: fuse, trim and self-test answers to a load start
// assumes start is a one-cycle pulse and the bench commands the failures
`timescale 1ns/1ps
module dcl_engine_model #(
  parameter logic [23:0] FUSE_IMAGE = 24'h85803C
) (
  input wire logic clock,
  input wire logic start,
  input wire logic [2:0] fails,
  output logic [23:0] fuse_data,
  output logic fuse_done,
  output logic fuse_fail,
  output logic trim_done,
  output logic trim_fail,
  output logic stest_done,
  output logic stest_fail
);
  int t = 0;
  initial {fuse_done, trim_done, stest_done} = 3'h0;
  // answers come out of order on purpose: trim, self-test, then fuse
  always @(posedge clock) begin
    t <= start ? 1 : (t != 0 && t < 9) ? t + 1 : 0;
    trim_done <= (t == 3);
    stest_done <= (t == 5);
    fuse_done <= (t == 7);
  end
  // fail lines are not qualified by done, so they hold the commanded fails value outside done pulses too
  assign trim_fail = fails[0];
  assign fuse_fail = fails[1];
  assign stest_fail = fails[2];
  assign fuse_data = fuse_done ? FUSE_IMAGE : ~FUSE_IMAGE;
endmodule

//--- bench/dcl_loader_props.sv
// checker bound onto the loader ports
// assumes supply_ok stays low until reset is over
`timescale 1ns/1ps
`include "dcl_defines.svh"
module dcl_loader_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic config_source_pin,
  input wire logic trial_enable_pin,
  input wire logic supply_ok,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_refused,
  input wire dcl_pkg::dcl_cfg_t functional,
  input wire logic [6:0] i2c_addr,
  input wire logic crc_enable,
  input wire logic watchdog_enable,
  input wire logic burn_allowed,
  input wire logic quiescent_off_state,
  input wire logic fuse_load_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_req; clk_en && (reg_wr || reg_rd); endsequence
  // pin synchroniser plus output register settle well inside six cycles
  sequence s_trial; (clk_en && trial_enable_pin) [*6]; endsequence
  ack_follows_a: assert property (s_req |=> reg_ack) else $error("request not acked");
  refused_ack_a: assert property (reg_refused |-> reg_ack) else $error("lone refusal");
  idle_rdata_a: assert property (!reg_ack |-> reg_rdata == 8'h00) else $error("stray data");
  trial_addr_a: assert property (s_trial |-> i2c_addr == `DCL_TRIAL_I2C_ADDR)
    else $error("trial address wrong");
  trial_crc_a: assert property (s_trial |-> !crc_enable) else $error("crc on in trial");
  trial_wdog_a: assert property (s_trial |-> !watchdog_enable) else $error("watchdog on");
  burn_gate_a: assert property (burn_allowed |-> quiescent_off_state) else $error("burn open");
  load_start_a: assert property ($rose(supply_ok) |-> ##[1:6] fuse_load_start)
    else $error("no fuse load after supply rise");
  image_load_a: assert property (config_source_pin [*8] ##0 $rose(quiescent_off_state)
    |-> functional == {`DCL_IMG_BUS_SETTINGS, `DCL_IMG_CONTROL_FIRST, `DCL_IMG_CONTROL_SECOND})
    else $error("image not loaded");
endmodule
bind dcl_loader dcl_loader_props i_dcl_loader_props (.clock(clock), .rst_n(rst_n),
  .clk_en(clk_en), .config_source_pin(config_source_pin), .trial_enable_pin(trial_enable_pin),
  .supply_ok(supply_ok), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_ack(reg_ack), .reg_refused(reg_refused), .functional(functional), .i2c_addr(i2c_addr),
  .crc_enable(crc_enable), .watchdog_enable(watchdog_enable), .burn_allowed(burn_allowed),
  .quiescent_off_state(quiescent_off_state), .fuse_load_start(fuse_load_start));

//--- bench/tb.sv
// self-checking bench of the default configuration loader
// assumes the engine model answers every fuse load start
`timescale 1ns/1ps
`include "dcl_defines.svh"
module tb;
  logic clock = 0, rst_n = 0, src = 0, trial = 0, sup = 0, pwr = 0, lpo = 0;
  logic wr = 0, rd = 0, ack, rf, fd, ff, td, tf, sd, sf, fls, crc, sw, wdg, burn, qoff, pon, r;
  logic [7:0] adr = 0, wd = 0, rdat, q;
  logic [6:0] i2c;
  logic [23:0] fdat;
  logic [2:0] fails = 0;
  dcl_pkg::dcl_cfg_t func;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #2.5 clock = ~clock;
  dcl_loader i_dcl_loader (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .config_source_pin(src), .trial_enable_pin(trial), .supply_ok(sup), .fuse_data(fdat),
    .fuse_done(fd), .fuse_fail(ff), .trim_done(td), .trim_fail(tf), .stest_done(sd),
    .stest_fail(sf), .power_up_request(pwr), .low_power_off_select(lpo), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(adr), .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack),
    .reg_refused(rf), .functional(func), .i2c_addr(i2c), .crc_enable(crc),
    .secure_write_enable(sw), .watchdog_enable(wdg), .burn_allowed(burn),
    .quiescent_off_state(qoff), .powered_on(pon), .fuse_load_start(fls));
  dcl_engine_model i_dcl_engine_model (.clock(clock), .start(fls), .fails(fails),
    .fuse_data(fdat), .fuse_done(fd), .fuse_fail(ff), .trim_done(td), .trim_fail(tf),
    .stest_done(sd), .stest_fail(sf));
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // the whole run needs a few hundred cycles; this only cuts a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task chk(input string n, input logic [23:0] s, input logic [23:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr = w;
    rd = !w;
    adr = a;
    wd = d;
    @(negedge clock);
    wr = 0;
    rd = 0;
    for (int i = 0; i < 3 && ack !== 1'b1; i++) @(negedge clock);
    chk("ack", ack, 1);
    q = rdat;
    r = rf;
    @(negedge clock);
  endtask
  task load(input logic [2:0] f);
    fails = f;
    sup = 0;
    wt(6);
    sup = 1;
    wt(3);
    for (int i = 0; i < 80 && qoff !== 1'b1; i++) @(negedge clock);
    chk("quiescent", qoff, 1);
  endtask
  task pu(input logic e);
    pwr = 1;
    wt(12);
    chk("powered", pon, e);
    pwr = 0;
    wt(6);
  endtask
  initial begin
    wt(12);
    rst_n = 1;
    wt(4);
    load(3'h0);
    chk("functional", func, 24'h85803C);
    chk("bus", {i2c, crc, sw, wdg}, {7'h0D, 3'h7});
    chk("no burn", burn, 0);
    acc(0, `DCL_ADDR_BUS_SETTINGS, 0); chk("mirror refused", r, 1);
    acc(1, `DCL_ADDR_PAGE, 1); chk("page refused", r, 1);
    lpo = 1;
    pu(0);
    lpo = 0;
    pu(1);
    $display("test normal done");
    trial = 1;
    wt(8);
    chk("trial bus", {i2c, crc, sw, wdg}, {7'h08, 3'h0});
    chk("burn", burn, 1);
    acc(1, `DCL_ADDR_PAGE, 1); chk("page", r, 0);
    acc(1, `DCL_ADDR_CONTROL_FIRST, 8'h44);
    acc(0, `DCL_ADDR_CONTROL_FIRST, 0); chk("mirror write", q, 8'h44);
    acc(0, `DCL_ADDR_BUS_SETTINGS, 0); chk("preload", q, 8'h85);
    load(3'h4);
    acc(1, `DCL_ADDR_PAGE, 1);
    acc(0, `DCL_ADDR_CONTROL_FIRST, 0); chk("mirror lost", q, 8'h80);
    acc(0, `DCL_ADDR_FLAGS, 0); chk("stest flag", q[2:0], 3'h4);
    pu(0);
    acc(1, `DCL_ADDR_FLAGS, 8'h04);
    acc(0, `DCL_ADDR_FLAGS, 0); chk("clear by 1", q[2:0], 3'h0);
    pu(1);
    trial = 0;
    load(3'h1);
    acc(1, `DCL_ADDR_FLAGS, 8'h01);
    acc(0, `DCL_ADDR_FLAGS, 0); chk("read only", q[2:0], 3'h1);
    pu(0);
    $display("test fuse done");
    src = 1;
    trial = 1;
    lpo = 1;
    load(3'h3);
    chk("image", func, 24'h000205);
    acc(0, `DCL_ADDR_FLAGS, 0); chk("image flags", q[2:0], 3'h1);
    acc(1, `DCL_ADDR_PAGE, 1); chk("no trial", r, 1);
    acc(1, `DCL_ADDR_FLAGS, 0);
    acc(0, `DCL_ADDR_FLAGS, 0); chk("clear by 0", q[2:0], 3'h0);
    pu(1);
    $display("test image done");
    final_report();
  end
endmodule
